// >>> rtl/ddcc_regs.svh
/*
 * register offsets, field positions, reset values and codes of the
 * downconverter channel configuration block.
 * assumes: included by bare name from the design file and the testbench.
 */
`ifndef DDCC_REGS_SVH
`define DDCC_REGS_SVH

`define DDCC_ADDR_TEST_EN     15'h0367
`define DDCC_ADDR_CTRL        15'h0370
`define DDCC_ADDR_ALT_DEC     15'h0371

`define DDCC_TEST_EN_MASK     8'h05
`define DDCC_CTRL_MASK        8'hff
`define DDCC_ALT_DEC_MASK     8'hf0
`define DDCC_RESET_BYTE       8'h00

`define DDCC_BIT_Q_TEST       2
`define DDCC_BIT_I_TEST       0
`define DDCC_BIT_MIX_SEL      7
`define DDCC_BIT_GAIN_SEL     6
`define DDCC_FLD_IF_HI        5
`define DDCC_FLD_IF_LO        4
`define DDCC_BIT_C2R          3
`define DDCC_FLD_DEC_HI       2
`define DDCC_FLD_DEC_LO       0
`define DDCC_FLD_ALT_HI       7
`define DDCC_FLD_ALT_LO       4

`define DDCC_DEC_HB12         3'h0
`define DDCC_DEC_HB123        3'h1
`define DDCC_DEC_HB1234       3'h2
`define DDCC_DEC_HB1          3'h3
`define DDCC_DEC_HB1_TB       3'h4
`define DDCC_DEC_HB12_TB      3'h5
`define DDCC_DEC_HB123_TB     3'h6
`define DDCC_DEC_ALT          3'h7

`define DDCC_ALT_HB1234_TB    4'h0
`define DDCC_ALT_FB_HB1       4'h2
`define DDCC_ALT_FB_HB12      4'h3
`define DDCC_ALT_FB_HB123     4'h4

`define DDCC_RATIO_W          6
`define DDCC_ONE_RATIO        6'h01
`define DDCC_STAGE_W          6

`endif

// >>> rtl/ddcc_pkg.sv
/*
 * types of the downconverter channel configuration block.
 * assumes: nothing beyond the constants header.
 */
`default_nettype none
package ddcc_pkg;

  typedef enum logic [1:0] {
    DDCC_IF_VARIABLE,
    DDCC_IF_ZERO,
    DDCC_IF_QUARTER,
    DDCC_IF_TEST
  } ddcc_if_mode_type;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } ddcc_req_type;

  // one complex sample
  typedef struct packed {
    logic        valid;
    logic [15:0] i;
    logic [15:0] q;
  } ddcc_smp_type;

  // decoded filter chain
  typedef struct packed {
    logic [5:0] stages;
    logic [5:0] ratio;
  } ddcc_chain_type;

  // all state of the block
  typedef struct packed {
    logic [7:0]       test_en;
    logic [7:0]       ctrl;
    logic [7:0]       alt_dec;
    logic [7:0]       rdata;
    logic             rvalid;
    logic [1:0]       quad;
    logic [5:0]       dec_cnt;
    ddcc_smp_type     out;
  } ddcc_state_type;

endpackage
`default_nettype wire

// >>> rtl/ddcc_core.sv
/*
 * downconverter channel configuration: control registers, test pattern
 * substitution, gain, complex-to-real quarter-rate mix and decimation.
 * assumes: register port and sample stream on i_clk_sys; pattern inputs
 * come from the pattern generators on the same clock.
 */
`default_nettype none
`include "ddcc_regs.svh"

module ddcc_core (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  input  wire ddcc_pkg::ddcc_req_type i_req,
  output var  logic [7:0]           o_rdata,
  output var  logic                 o_rvalid,
  input  wire ddcc_pkg::ddcc_smp_type i_smp,
  input  wire logic [15:0]          i_pat_a,
  input  wire logic [15:0]          i_pat_b,
  output var  ddcc_pkg::ddcc_smp_type o_smp,
  output var  logic                 o_q_valid,
  output var  logic                 o_complex_mix,
  output var  ddcc_pkg::ddcc_if_mode_type o_if_mode,
  output var  logic [5:0]           o_stage_en,
  output var  logic [5:0]           o_dec_ratio
);

  ddcc_pkg::ddcc_state_type st_ff;
  ddcc_pkg::ddcc_state_type nxt_st;
  ddcc_pkg::ddcc_chain_type chain;
  logic                     c2r;
  logic [2:0]               dec_code;
  logic [15:0]              s_i;
  logic [15:0]              s_q;
  logic [15:0]              g_i;
  logic [15:0]              g_q;

  // ***********************************************
  // filter chain decode
  // ***********************************************
  // stages bit order: hb1, hb2, hb3, hb4, third-band, fifth-band
  always_comb begin
    chain = '0;
    unique case (st_ff.ctrl[`DDCC_FLD_DEC_HI:`DDCC_FLD_DEC_LO])
      `DDCC_DEC_HB12: begin
        chain.stages = 6'h03;
        chain.ratio  = 6'h02;
      end
      `DDCC_DEC_HB123: begin
        chain.stages = 6'h07;
        chain.ratio  = 6'h04;
      end
      `DDCC_DEC_HB1234: begin
        chain.stages = 6'h0f;
        chain.ratio  = 6'h08;
      end
      `DDCC_DEC_HB1: begin
        chain.stages = 6'h01;
        chain.ratio  = 6'h01;
      end
      `DDCC_DEC_HB1_TB: begin
        chain.stages = 6'h11;
        chain.ratio  = 6'h03;
      end
      `DDCC_DEC_HB12_TB: begin
        chain.stages = 6'h13;
        chain.ratio  = 6'h06;
      end
      `DDCC_DEC_HB123_TB: begin
        chain.stages = 6'h17;
        chain.ratio  = 6'h0c;
      end
      `DDCC_DEC_ALT: begin
        unique case (st_ff.alt_dec[`DDCC_FLD_ALT_HI:`DDCC_FLD_ALT_LO])
          `DDCC_ALT_HB1234_TB: begin
            chain.stages = 6'h1f;
            chain.ratio  = 6'h18;
          end
          `DDCC_ALT_FB_HB1: begin
            chain.stages = 6'h21;
            chain.ratio  = 6'h05;
          end
          `DDCC_ALT_FB_HB12: begin
            chain.stages = 6'h23;
            chain.ratio  = 6'h0a;
          end
          `DDCC_ALT_FB_HB123: begin
            chain.stages = 6'h27;
            chain.ratio  = 6'h14;
          end
          default: begin
            chain.stages = 6'h01;
            chain.ratio  = 6'h01;
          end
        endcase
      end
    endcase
    // ratio above is for real output; complex output doubles it
    if (!c2r) begin
      chain.ratio = {chain.ratio[4:0], 1'b0};
    end
  end

  // ***********************************************
  // sample path
  // ***********************************************
  assign c2r = st_ff.ctrl[`DDCC_BIT_C2R];
  assign dec_code = st_ff.ctrl[`DDCC_FLD_DEC_HI:`DDCC_FLD_DEC_LO];

  always_comb begin
    // real mixer uses the i input on both arms
    s_i = i_smp.i;
    s_q = st_ff.ctrl[`DDCC_BIT_MIX_SEL] ? i_smp.q : i_smp.i;
    g_i = st_ff.ctrl[`DDCC_BIT_GAIN_SEL] ? {s_i[14:0], 1'b0} : s_i;
    g_q = st_ff.ctrl[`DDCC_BIT_GAIN_SEL] ? {s_q[14:0], 1'b0} : s_q;
    // quarter-rate mix: i, -q, -i, q
    if (c2r) begin
      unique case (st_ff.quad)
        2'h0: g_i = g_i;
        2'h1: g_i = 16'h0000 - g_q;
        2'h2: g_i = 16'h0000 - g_i;
        2'h3: g_i = g_q;
      endcase
    end
  end

  // ***********************************************
  // register port and state update
  // ***********************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    if (i_req.wr) begin
      unique case (i_req.addr)
        `DDCC_ADDR_TEST_EN: nxt_st.test_en = i_req.wdata & `DDCC_TEST_EN_MASK;
        `DDCC_ADDR_CTRL:    nxt_st.ctrl    = i_req.wdata & `DDCC_CTRL_MASK;
        `DDCC_ADDR_ALT_DEC: nxt_st.alt_dec = i_req.wdata & `DDCC_ALT_DEC_MASK;
        default: ;
      endcase
    end
    if (i_req.rd) begin
      nxt_st.rvalid = 1'b1;
      unique case (i_req.addr)
        `DDCC_ADDR_TEST_EN: nxt_st.rdata = st_ff.test_en;
        `DDCC_ADDR_CTRL:    nxt_st.rdata = st_ff.ctrl;
        `DDCC_ADDR_ALT_DEC: nxt_st.rdata = st_ff.alt_dec;
        default:            nxt_st.rdata = `DDCC_RESET_BYTE;
      endcase
    end
    nxt_st.out.valid = 1'b0;
    if (i_smp.valid) begin
      nxt_st.quad = st_ff.quad + 2'h1;
      if (st_ff.dec_cnt >= chain.ratio - `DDCC_ONE_RATIO) begin
        nxt_st.dec_cnt   = '0;
        nxt_st.out.valid = 1'b1;
        nxt_st.out.i = st_ff.test_en[`DDCC_BIT_I_TEST] ? i_pat_a : g_i;
        if (c2r) begin
          nxt_st.out.q = '0;
        end else begin
          nxt_st.out.q = st_ff.test_en[`DDCC_BIT_Q_TEST] ? i_pat_b : g_q;
        end
      end else begin
        nxt_st.dec_cnt = st_ff.dec_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata       = st_ff.rdata;
  assign o_rvalid      = st_ff.rvalid;
  assign o_smp         = st_ff.out;
  assign o_q_valid     = st_ff.out.valid & ~c2r;
  assign o_complex_mix = st_ff.ctrl[`DDCC_BIT_MIX_SEL];
  assign o_if_mode     = ddcc_pkg::ddcc_if_mode_type'(
                           st_ff.ctrl[`DDCC_FLD_IF_HI:`DDCC_FLD_IF_LO]);
  assign o_stage_en    = chain.stages;
  assign o_dec_ratio   = chain.ratio;

  // ***********************************************
  // assertions
  // ***********************************************
  // read strobe taken; its answer follows one cycle later
  sequence s_rd_take;
    i_ce && i_req.rd;
  endsequence
  // sample taken that closes a decimation group
  sequence s_dec_take;
    i_ce && i_smp.valid && (st_ff.dec_cnt >= chain.ratio - `DDCC_ONE_RATIO);
  endsequence

  a_reserved_test_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (st_ff.test_en & ~`DDCC_TEST_EN_MASK) == 8'h00)
    else $error("reserved test bit set");
  a_reset_zero: assert property (
    @(posedge i_clk_sys)
    !i_rst_b |=> st_ff == '0)
    else $error("state not cleared by reset");
  a_read_answer: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_rd_take |=> o_rvalid)
    else $error("read not answered");
  a_unmapped_read: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_rd_take ##0 (i_req.addr != `DDCC_ADDR_TEST_EN && i_req.addr != `DDCC_ADDR_CTRL
      && i_req.addr != `DDCC_ADDR_ALT_DEC) |=> o_rdata == `DDCC_RESET_BYTE)
    else $error("unmapped read not zero");
  a_q_pattern_used: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && st_ff.test_en[`DDCC_BIT_Q_TEST] && !c2r
    |=> o_smp.q == $past(i_pat_b))
    else $error("q pattern not used");
  a_q_test_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && !st_ff.test_en[`DDCC_BIT_Q_TEST] && !c2r
    |=> o_smp.q == $past(g_q))
    else $error("q pattern used while off");
  a_i_pattern_used: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && st_ff.test_en[`DDCC_BIT_I_TEST]
    |=> o_smp.i == $past(i_pat_a))
    else $error("i pattern not used");
  a_i_test_off: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && !st_ff.test_en[`DDCC_BIT_I_TEST] && !c2r
    |=> o_smp.i == $past(g_i))
    else $error("i pattern used while off");
  a_real_mix_arm: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !st_ff.ctrl[`DDCC_BIT_MIX_SEL] |-> s_q == i_smp.i)
    else $error("real mixer arm wrong");
  a_cplx_mix_arm: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    st_ff.ctrl[`DDCC_BIT_MIX_SEL] |-> s_q == i_smp.q)
    else $error("complex mixer arm wrong");
  a_gain_double: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    st_ff.ctrl[`DDCC_BIT_GAIN_SEL] |-> g_q == {s_q[14:0], 1'b0})
    else $error("gain wrong");
  a_q_valid_c2r: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    o_q_valid |-> !c2r && o_smp.valid)
    else $error("q valid in real mode");
  a_q_valid_complex: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && !c2r && !(i_req.wr && i_req.addr == `DDCC_ADDR_CTRL)
    |=> o_q_valid)
    else $error("q valid missing in complex mode");
  a_c2r_q_zero: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_dec_take ##0 c2r |=> o_smp.q == 16'h0000)
    else $error("q not cleared in real mode");
  a_mix_quad_one: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && c2r && st_ff.quad == 2'h1
    && !st_ff.test_en[`DDCC_BIT_I_TEST] && !st_ff.ctrl[`DDCC_BIT_GAIN_SEL]
    |=> o_smp.i == 16'h0000 - $past(s_q))
    else $error("quarter mix phase one wrong");
  a_mix_quad_two: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && nxt_st.out.valid && c2r && st_ff.quad == 2'h2
    && !st_ff.test_en[`DDCC_BIT_I_TEST] && !st_ff.ctrl[`DDCC_BIT_GAIN_SEL]
    |=> o_smp.i == 16'h0000 - $past(s_i))
    else $error("quarter mix phase two wrong");
  a_dec_output: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    s_dec_take |=> o_smp.valid)
    else $error("decimated sample missing");
  a_dec_code0: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB12 |-> o_dec_ratio == (c2r ? 6'h02 : 6'h04))
    else $error("code 000 ratio");
  a_dec_code1: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB123 |-> o_dec_ratio == (c2r ? 6'h04 : 6'h08))
    else $error("code 001 ratio");
  a_dec_code2: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB1234 |-> o_stage_en == 6'h0f)
    else $error("code 010 chain");
  a_dec_code3: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB1 |-> o_dec_ratio == (c2r ? 6'h01 : 6'h02))
    else $error("code 011 ratio");
  a_dec_code4: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB1_TB |-> o_stage_en == 6'h11)
    else $error("code 100 chain");
  a_dec_code5: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_HB12_TB |-> o_dec_ratio == (c2r ? 6'h06 : 6'h0c))
    else $error("code 101 ratio");
  a_alt_field: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    dec_code == `DDCC_DEC_ALT
    && st_ff.alt_dec[`DDCC_FLD_ALT_HI:`DDCC_FLD_ALT_LO] == `DDCC_ALT_FB_HB1
    |-> o_stage_en == 6'h21)
    else $error("alternate chain");
  a_if_mode_map: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    i_ce && i_req.wr && i_req.addr == `DDCC_ADDR_CTRL
    |=> o_if_mode == $past(i_req.wdata[`DDCC_FLD_IF_HI:`DDCC_FLD_IF_LO]))
    else $error("if mode");

endmodule
`default_nettype wire

// >>> verification/ddcc_adc_src.sv
/*
 * sample source standing in for the converter channels feeding ddcc_core.
 * assumes: driven from the bench clock and reset; samples change at the
 * falling edge; i_real set means both arms carry one real channel.
 */
`default_nettype none
module ddcc_adc_src (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_b,
  input  wire logic             i_real,
  output var  ddcc_pkg::ddcc_smp_type o_smp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] v;
  always @(negedge i_clk_sys) begin
    v = 16'($urandom);
    if (i_rst_b && $urandom_range(2, 0) != 0) begin
      o_smp.valid <= 1'b1;
      o_smp.i     <= v;
      o_smp.q     <= i_real ? v : 16'($urandom);
    end else begin
      // no stale data between strobes
      o_smp.valid <= 1'b0;
      o_smp.i     <= ~o_smp.i;
      o_smp.q     <= ~o_smp.q;
    end
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
/*
 * self-checking bench of ddcc_core: registers, chain decode, sample path.
 * assumes: ddcc_adc_src supplies samples; inputs change at falling edges.
 */
`default_nettype none
`include "ddcc_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   i_clk_sys, i_rst_b, i_ce, i_real, mon_on, seen;
  logic                   o_rvalid, o_q_valid, o_complex_mix;
  ddcc_pkg::ddcc_req_type i_req;
  ddcc_pkg::ddcc_smp_type i_smp, o_smp, ls;
  ddcc_pkg::ddcc_if_mode_type o_if_mode;
  logic [15:0]            i_pat_a, i_pat_b, la, lb, ei;
  logic [1:0]             lq;
  logic [7:0]             o_rdata, c_ctrl, c_ten, c_alt, d, cv;
  logic [5:0]             o_stage_en, o_dec_ratio;
  int                     num_errors, check_count, ninp, nout, n, a, k, nq;
  int                     atab[5] = '{0, 2, 3, 4, 9};

  ddcc_core dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_req(i_req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_smp(i_smp), .i_pat_a(i_pat_a),
    .i_pat_b(i_pat_b), .o_smp(o_smp), .o_q_valid(o_q_valid), .o_complex_mix(o_complex_mix),
    .o_if_mode(o_if_mode), .o_stage_en(o_stage_en), .o_dec_ratio(o_dec_ratio));
  ddcc_adc_src src (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_real(i_real),
    .o_smp(i_smp));

  function automatic logic [5:0] exp_ratio(logic [7:0] c, logic [7:0] al);
    logic [5:0] rt[7] = '{6'h02, 6'h04, 6'h08, 6'h01, 6'h03, 6'h06, 6'h0c};
    logic [5:0] r;
    r = 6'h01;
    if (c[2:0] != 3'h7) r = rt[c[2:0]];
    else if (al[7:4] == 4'h0) r = 6'h18;
    else if (al[7:4] == 4'h2) r = 6'h05;
    else if (al[7:4] == 4'h3) r = 6'h0a;
    else if (al[7:4] == 4'h4) r = 6'h14;
    return c[3] ? r : 6'(r << 1);
  endfunction
  function automatic logic [5:0] exp_stages(logic [7:0] c, logic [7:0] al);
    logic [5:0] st[7] = '{6'h03, 6'h07, 6'h0f, 6'h01, 6'h11, 6'h13, 6'h17};
    logic [5:0] s;
    s = 6'h01;
    if (c[2:0] != 3'h7) s = st[c[2:0]];
    else if (al[7:4] == 4'h0) s = 6'h1f;
    else if (al[7:4] == 4'h2) s = 6'h21;
    else if (al[7:4] == 4'h3) s = 6'h23;
    else if (al[7:4] == 4'h4) s = 6'h27;
    return s;
  endfunction
  // quarter-rate mix by sample phase: i, -q, -i, q
  function automatic logic [15:0] qmix(logic [1:0] ph, logic [15:0] vi, logic [15:0] vq);
    unique case (ph)
      2'h0: return vi;
      2'h1: return 16'h0000 - vq;
      2'h2: return 16'h0000 - vi;
      default: return vq;
    endcase
  endfunction
  function automatic logic [15:0] gain(logic [15:0] v);
    return c_ctrl[6] ? 16'(v << 1) : v;
  endfunction

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [14:0] ad, logic [7:0] dv);
    i_req = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dv};
    @(negedge i_clk_sys);
    i_req.wr = 1'b0;
    @(negedge i_clk_sys);
  endtask
  task automatic rd_chk(string nm, logic [14:0] ad, logic [7:0] e);
    i_req = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(negedge i_clk_sys);
    i_req.rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, o_rvalid});
    chk(nm, {8'h00, e}, {8'h00, o_rdata});
    @(negedge i_clk_sys);
    chk("rvalid_end", 16'h0000, {15'h0000, o_rvalid});
  endtask
  task automatic run(logic [7:0] c, logic [7:0] t, logic [7:0] al);
    mon_on = 1'b0;
    c_ctrl = c;
    c_ten = t;
    c_alt = al;
    i_real = ~c[7];
    wr_reg(`DDCC_ADDR_CTRL, c);
    wr_reg(`DDCC_ADDR_TEST_EN, t);
    wr_reg(`DDCC_ADDR_ALT_DEC, al);
    seen = 1'b0;
    nout = 0;
    mon_on = 1'b1;
    for (k = 0; k < 2000 && nout < 6; k++) @(negedge i_clk_sys);
    chk("outputs", 16'h0006, nout[15:0]);
    mon_on = 1'b0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ******************************************************
  // clock, watchdog, pattern sources, output monitor
  // ******************************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #1_000_000;
    num_errors++;
    results();
  end
  always @(negedge i_clk_sys) begin
    i_pat_a <= 16'($urandom);
    i_pat_b <= 16'($urandom);
  end
  // output seen here was launched by the sample held in ls
  always @(posedge i_clk_sys) begin
    if (mon_on && o_smp.valid === 1'b1) begin
      if (seen) chk("ratio_run", {10'h000, exp_ratio(c_ctrl, c_alt)}, ninp[15:0]);
      chk("q_valid", {15'h0000, ~c_ctrl[3]}, {15'h0000, o_q_valid});
      ei = c_ctrl[3] ? qmix(lq, gain(ls.i), gain(c_ctrl[7] ? ls.q : ls.i)) : gain(ls.i);
      chk("i", c_ten[0] ? la : ei, o_smp.i);
      chk("q", c_ctrl[3] ? 16'h0000 : c_ten[2] ? lb : gain(c_ctrl[7] ? ls.q : ls.i),
        o_smp.q);
      seen = 1'b1;
      ninp = 0;
      nout++;
    end
    if (i_rst_b && i_smp.valid && i_ce) begin
      ninp++;
      lq = nq[1:0];
      nq++;
      ls = i_smp;
      la = i_pat_a;
      lb = i_pat_b;
    end
  end

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    void'($urandom(92));
    {i_rst_b, mon_on, seen, i_real, i_ce} = 5'b00011;
    {num_errors, check_count, ninp, nout, nq} = '0;
    {i_req, c_ctrl, c_ten, c_alt} = '0;
    repeat (12) @(negedge i_clk_sys);
    i_rst_b = 1'b1;
    chk("ratio_rst", 16'h0004, {10'h000, o_dec_ratio});
    rd_chk("ten_rst", `DDCC_ADDR_TEST_EN, 8'h00);
    rd_chk("ctrl_rst", `DDCC_ADDR_CTRL, 8'h00);
    rd_chk("alt_rst", `DDCC_ADDR_ALT_DEC, 8'h00);
    d = 8'($urandom) | 8'hfa;
    wr_reg(`DDCC_ADDR_TEST_EN, d);
    rd_chk("ten", `DDCC_ADDR_TEST_EN, d & 8'h05);
    d = 8'($urandom);
    wr_reg(`DDCC_ADDR_ALT_DEC, d);
    rd_chk("alt", `DDCC_ADDR_ALT_DEC, d & 8'hf0);
    wr_reg(`DDCC_ADDR_CTRL, d);
    rd_chk("ctrl", `DDCC_ADDR_CTRL, d);
    wr_reg(15'h0368, 8'hff);
    rd_chk("unmapped", 15'h0368, 8'h00);
    i_ce = 1'b0;
    wr_reg(`DDCC_ADDR_CTRL, ~d);
    i_ce = 1'b1;
    rd_chk("ce_hold", `DDCC_ADDR_CTRL, d);
    for (n = 0; n < 16; n++) begin
      cv = (8'($urandom) & 8'hc0) | (8'(n << 4) & 8'h30) | 8'(n);
      wr_reg(`DDCC_ADDR_CTRL, cv);
      chk("mix", {15'h0000, cv[7]}, {15'h0000, o_complex_mix});
      chk("if_mode", {14'h0000, cv[5:4]}, {14'h0000, o_if_mode});
      for (a = 0; a < 5; a++) begin
        wr_reg(`DDCC_ADDR_ALT_DEC, 8'(atab[a] << 4));
        chk("ratio", {10'h000, exp_ratio(cv, 8'(atab[a] << 4))},
          {10'h000, o_dec_ratio});
        chk("stages", {10'h000, exp_stages(cv, 8'(atab[a] << 4))},
          {10'h000, o_stage_en});
      end
    end
    run(8'h83 | (8'($urandom) & 8'h30), 8'h00, 8'h00);
    run(8'h43 | (8'($urandom) & 8'h30), 8'h00, 8'h00);
    run(8'hc4, 8'h05, 8'h00);
    run(8'h0b, 8'h00, 8'h00);
    run(8'hc8, 8'h04, 8'h00);
    run(8'h87, 8'h01, 8'h20);
    results();
  end
endmodule
`default_nettype wire
